// >>> hw/irs_slave.sv
`include "irs_defs.svh"

module irs_slave #(
  parameter logic [6:0] SLAVE_ADDR = `IRS_SLAVE_ADDR
)(
  input wire logic CLOCK,
  input wire logic RESET_N,
  irs_if.slave I2C,
  output irs_pkg::irs_addr_t REG_ADDR,
  output irs_pkg::irs_byte_t REG_WDATA,
  output logic REG_WR,
  output logic REG_RD,
  input wire irs_pkg::irs_byte_t REG_RDATA,
  output logic BUSY
);
  import irs_pkg::*;

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  // Three flops per pin and no spike filter, so slow edges must be clean
  logic scl_m_r;
  logic scl_s_r;
  logic scl_d_r;
  logic sda_m_r;
  logic sda_s_r;
  logic sda_d_r;

  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
    begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else
    begin
      scl_m_r <= I2C.scl;
      scl_s_r <= scl_m_r;
      scl_d_r <= scl_s_r;
      sda_m_r <= I2C.sda;
      sda_s_r <= sda_m_r;
      sda_d_r <= sda_s_r;
    end
  end

  // ==========================================================
  // Bus event decode
  // ==========================================================
  irs_sst_e st_r;
  logic [3:0] bit_r;
  logic [7:0] sh_r;
  logic [7:0] tx_r;
  logic sda_oe_r;
  logic rw_r;
  logic busy_r;
  logic [1:0] idx_r;
  logic [7:0] hi_r;
  irs_addr_t ptr_r;
  irs_byte_t wdata_r;
  logic we_r;
  logic rd_r;

  // Sampling every system clock keeps both bus rates well resolved
  wire scl_rise = scl_s_r & ~scl_d_r;
  wire scl_fall = ~scl_s_r & scl_d_r;
  wire scl_high = scl_s_r & scl_d_r;
  wire start_det = scl_high & sda_d_r & ~sda_s_r;
  wire stop_det = scl_high & ~sda_d_r & sda_s_r;
  wire active = (st_r != S_IDLE);
  wire byte_end = active & scl_fall & (bit_r == `IRS_LAST_BIT);
  wire ack_end = active & scl_fall & (bit_r == `IRS_ACK_BIT);
  wire ack_rise = active & scl_rise & (bit_r == `IRS_ACK_BIT);
  wire data_rise = active & scl_rise & (bit_r != `IRS_ACK_BIT);
  wire addr_hit = (sh_r[7:1] == SLAVE_ADDR);
  wire rx_byte = byte_end & (st_r == S_RX);
  wire tx_load = ack_end & ((st_r == S_TX) | ((st_r == S_ADDR) & rw_r));
  wire idx_last = (idx_r == `IRS_IDX_DATA);

  // ==========================================================
  // Protocol state machine
  // ==========================================================
  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
    begin
      st_r <= S_IDLE;
      bit_r <= `IRS_FIRST_BIT;
      sh_r <= 8'h00;
      tx_r <= 8'h00;
      sda_oe_r <= 1'b0;
      rw_r <= 1'b0;
    end
    else if (start_det)
    begin
      // Repeated start also lands here, so it doubles as a stop
      st_r <= S_ADDR;
      // The start's own SCL fall wraps the count onto the first bit
      bit_r <= `IRS_PRE_BIT;
      sda_oe_r <= 1'b0;
    end
    else if (stop_det)
    begin
      st_r <= S_IDLE;
      sda_oe_r <= 1'b0;
    end
    else if (data_rise)
    begin
      sh_r <= {sh_r[6:0], sda_s_r};
    end
    else if (ack_rise)
    begin
      if ((st_r == S_TX) && sda_s_r)
      begin
        st_r <= S_IDLE;
      end
    end
    else if (byte_end)
    begin
      bit_r <= `IRS_ACK_BIT;
      case (st_r)
        S_ADDR:
        begin
          if (addr_hit)
          begin
            sda_oe_r <= 1'b1;
            rw_r <= sh_r[0];
          end
          else
          begin
            st_r <= S_IDLE;
          end
        end
        S_RX:
        begin
          sda_oe_r <= 1'b1;
        end
        default:
        begin
          sda_oe_r <= 1'b0;
        end
      endcase
    end
    else if (ack_end)
    begin
      bit_r <= `IRS_FIRST_BIT;
      if (st_r == S_ADDR)
      begin
        st_r <= rw_r ? S_TX : S_RX;
      end
      if (tx_load)
      begin
        sda_oe_r <= ~REG_RDATA[7];
        tx_r <= {REG_RDATA[6:0], 1'b0};
      end
      else
      begin
        sda_oe_r <= 1'b0;
      end
    end
    else if (active && scl_fall)
    begin
      bit_r <= bit_r + 4'h1;
      if (st_r == S_TX)
      begin
        sda_oe_r <= ~tx_r[7];
        tx_r <= {tx_r[6:0], 1'b0};
      end
    end
  end

  // ==========================================================
  // Register port
  // ==========================================================
  // Pointer moves the cycle after a strobe, so the strobe sees the old address
  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
    begin
      ptr_r <= `IRS_PTR_RST;
      hi_r <= 8'h00;
      idx_r <= `IRS_IDX_HI;
      wdata_r <= 8'h00;
      we_r <= 1'b0;
      rd_r <= 1'b0;
      busy_r <= 1'b0;
    end
    else
    begin
      busy_r <= active;
      we_r <= rx_byte & idx_last;
      rd_r <= tx_load;
      if (start_det)
      begin
        idx_r <= `IRS_IDX_HI;
      end
      else if (rx_byte && !idx_last)
      begin
        idx_r <= idx_r + 2'h1;
      end
      if (rx_byte && (idx_r == `IRS_IDX_HI))
      begin
        hi_r <= sh_r;
      end
      if (rx_byte)
      begin
        wdata_r <= sh_r;
      end
      if (rx_byte && (idx_r == `IRS_IDX_LO))
      begin
        ptr_r <= {hi_r, sh_r};
      end
      else if (we_r || rd_r)
      begin
        ptr_r <= ptr_r + 16'h0001;
      end
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  // Open drain: the low level is all this end ever drives, and never on SCL
  assign I2C.s_sda_o = 1'b0;
  assign I2C.s_sda_oe = sda_oe_r;
  assign REG_ADDR = ptr_r;
  assign REG_WDATA = wdata_r;
  assign REG_WR = we_r;
  assign REG_RD = rd_r;
  assign BUSY = busy_r;

endmodule // irs_slave

// >>> inc/irs_defs.svh
`ifndef IRS_DEFS_SVH
`define IRS_DEFS_SVH

// ==========================================================
// System clock and serial clock rates
// ==========================================================
`define IRS_CLK_KHZ 100000
`define IRS_SCL_KHZ_STD 100
`define IRS_SCL_KHZ_FAST 400

// ==========================================================
// Slave address and pointer reset
// ==========================================================
`define IRS_SLAVE_ADDR 7'h2A
`define IRS_PTR_RST 16'h0000

// ==========================================================
// Bit slots within one nine-pulse byte frame
// ==========================================================
`define IRS_FIRST_BIT 4'h0
`define IRS_LAST_BIT 4'h7
`define IRS_ACK_BIT 4'h8
`define IRS_PRE_BIT 4'hF

// ==========================================================
// Byte index within a write transfer
// ==========================================================
`define IRS_IDX_HI 2'h0
`define IRS_IDX_LO 2'h1
`define IRS_IDX_DATA 2'h2

// ==========================================================
// Master quarter phases of one SCL period
// ==========================================================
`define IRS_PH_DRIVE 2'h0
`define IRS_PH_RISE 2'h1
`define IRS_PH_SAMPLE 2'h2
`define IRS_PH_FALL 2'h3

// ==========================================================
// Command buffer
// ==========================================================
`define IRS_FIFO_DEPTH 8

`endif

// >>> inc/irs_pkg.sv
package irs_pkg;

  typedef logic [7:0] irs_byte_t;
  typedef logic [15:0] irs_addr_t;

  typedef enum logic [2:0] {
    IRS_CMD_START,
    IRS_CMD_WRITE,
    IRS_CMD_READ,
    IRS_CMD_READ_LAST,
    IRS_CMD_STOP
  } irs_cmd_e;

  typedef enum logic [1:0] {
    S_IDLE,
    S_ADDR,
    S_RX,
    S_TX
  } irs_sst_e;

  typedef enum logic [1:0] {
    M_IDLE,
    M_START,
    M_BYTE,
    M_STOP
  } irs_mst_e;

endpackage

// >>> inc/irs_if.sv
// ==========================================================
// Two-wire bus with open-drain resolution
// ==========================================================
interface irs_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;

  // Pull-up wins unless some driver pulls low
  assign scl = ~(m_scl_oe & ~m_scl_o);
  assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));

  modport master(
    input sda,
    output m_scl_o,
    output m_scl_oe,
    output m_sda_o,
    output m_sda_oe
  );

  modport slave(
    input scl,
    input sda,
    output s_sda_o,
    output s_sda_oe
  );
endinterface

// >>> hw/irs_master.sv
`include "irs_defs.svh"

// ==========================================================
// Command buffer (DEPTH must be a power of two)
// ==========================================================
module irs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `IRS_FIFO_DEPTH
)(
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic [WIDTH-1:0] IN_DATA,
  input wire logic IN_VALID,
  output logic IN_READY,
  output logic [WIDTH-1:0] OUT_DATA,
  output logic OUT_VALID,
  input wire logic OUT_READY
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic rdy_r;

  wire push = IN_VALID & rdy_r;
  wire pop = OUT_VALID & OUT_READY;
  wire [AW:0] cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  assign OUT_VALID = (cnt_r != '0);
  assign OUT_DATA = mem_r[rp_r];
  assign IN_READY = rdy_r;

  always_ff @(posedge CLOCK)
  begin
    if (push)
    begin
      mem_r[wp_r] <= IN_DATA;
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      rdy_r <= 1'b0;
    end
    else
    begin
      wp_r <= wp_r + AW'(push);
      rp_r <= rp_r + AW'(pop);
      cnt_r <= cnt_nxt;
      rdy_r <= (cnt_nxt != (AW+1)'(DEPTH));
    end
  end
endmodule // irs_fifo

// ==========================================================
// Bus master end
// ==========================================================
module irs_master #(
  parameter int SCL_KHZ = `IRS_SCL_KHZ_STD
)(
  input wire logic CLOCK,
  input wire logic RESET_N,
  irs_if.master I2C,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire irs_pkg::irs_cmd_e CMD_OP,
  input wire irs_pkg::irs_byte_t CMD_DATA,
  output irs_pkg::irs_byte_t RX_DATA,
  output logic RX_VALID,
  output logic ACK_OK,
  output logic IDLE
);
  import irs_pkg::*;

  localparam int CW = $bits(irs_cmd_e) + 8;
  localparam int QTR_RAW = `IRS_CLK_KHZ / (4 * SCL_KHZ);
  localparam int QTR = (QTR_RAW < 1) ? 1 : QTR_RAW;

  logic [CW-1:0] f_data;
  logic f_valid;
  irs_mst_e st_r;
  logic [1:0] ph_r;
  logic [3:0] bit_r;
  logic [7:0] sh_r;
  logic [15:0] div_r;
  logic rdop_r;
  logic nack_r;
  logic scl_oe_r;
  logic sda_oe_r;
  logic sda_m_r;
  logic sda_s_r;
  irs_byte_t rx_r;
  logic rxv_r;
  logic ack_r;
  logic idle_r;

  wire f_take = (st_r == M_IDLE);

  // A full buffer stalls the user through CMD_READY
  irs_fifo #(.WIDTH(CW), .DEPTH(`IRS_FIFO_DEPTH)) u_fifo (
    .CLOCK(CLOCK),
    .RESET_N(RESET_N),
    .IN_DATA({CMD_OP, CMD_DATA}),
    .IN_VALID(CMD_VALID),
    .IN_READY(CMD_READY),
    .OUT_DATA(f_data),
    .OUT_VALID(f_valid),
    .OUT_READY(f_take)
  );

  wire fetch = f_take & f_valid;
  wire irs_cmd_e f_op = irs_cmd_e'(f_data[CW-1:8]);
  wire tick = (div_r == 16'(QTR - 1));
  wire step = tick & (st_r != M_IDLE);
  wire ack_slot = (bit_r == `IRS_ACK_BIT);
  // Write bytes drive the shifter MSB; reads float except for their own ack
  wire drive_low = ack_slot ? (rdop_r & ~nack_r) : (~rdop_r & ~sh_r[7]);

  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
    begin
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      div_r <= 16'h0000;
      idle_r <= 1'b1;
    end
    else
    begin
      sda_m_r <= I2C.sda;
      sda_s_r <= sda_m_r;
      div_r <= (tick || fetch) ? 16'h0000 : div_r + 16'h0001;
      idle_r <= (st_r == M_IDLE) & ~f_valid;
    end
  end

  // ==========================================================
  // Quarter-phase sequencer
  // ==========================================================
  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
    begin
      st_r <= M_IDLE;
      ph_r <= `IRS_PH_DRIVE;
      bit_r <= `IRS_FIRST_BIT;
      sh_r <= 8'h00;
      rdop_r <= 1'b0;
      nack_r <= 1'b0;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      rx_r <= 8'h00;
      rxv_r <= 1'b0;
      ack_r <= 1'b0;
    end
    else
    begin
      rxv_r <= 1'b0;
      if (fetch)
      begin
        ph_r <= `IRS_PH_DRIVE;
        bit_r <= `IRS_FIRST_BIT;
        sh_r <= f_data[7:0];
        rdop_r <= (f_op == IRS_CMD_READ) | (f_op == IRS_CMD_READ_LAST);
        nack_r <= (f_op == IRS_CMD_READ_LAST);
        case (f_op)
          IRS_CMD_START: st_r <= M_START;
          IRS_CMD_STOP: st_r <= M_STOP;
          default: st_r <= M_BYTE;
        endcase
      end
      else if (step)
      begin
        ph_r <= ph_r + 2'h1;
        case (st_r)
          M_START:
          begin
            // Release SDA first so a repeated start works from SCL low
            if (ph_r == `IRS_PH_DRIVE) sda_oe_r <= 1'b0;
            if (ph_r == `IRS_PH_RISE) scl_oe_r <= 1'b0;
            if (ph_r == `IRS_PH_SAMPLE) sda_oe_r <= 1'b1;
            if (ph_r == `IRS_PH_FALL) scl_oe_r <= 1'b1;
            if (ph_r == `IRS_PH_FALL) st_r <= M_IDLE;
          end
          M_STOP:
          begin
            if (ph_r == `IRS_PH_DRIVE) sda_oe_r <= 1'b1;
            if (ph_r == `IRS_PH_RISE) scl_oe_r <= 1'b0;
            if (ph_r == `IRS_PH_SAMPLE) sda_oe_r <= 1'b0;
            if (ph_r == `IRS_PH_FALL) st_r <= M_IDLE;
          end
          M_BYTE:
          begin
            if (ph_r == `IRS_PH_DRIVE) sda_oe_r <= drive_low;
            if (ph_r == `IRS_PH_RISE) scl_oe_r <= 1'b0;
            if (ph_r == `IRS_PH_SAMPLE && !ack_slot) sh_r <= {sh_r[6:0], sda_s_r};
            if (ph_r == `IRS_PH_SAMPLE && ack_slot) ack_r <= ~sda_s_r;
            if (ph_r == `IRS_PH_FALL)
            begin
              scl_oe_r <= 1'b1;
              bit_r <= bit_r + 4'h1;
              if (ack_slot)
              begin
                st_r <= M_IDLE;
                rx_r <= sh_r;
                rxv_r <= rdop_r;
              end
            end
          end
          default: st_r <= M_IDLE;
        endcase
      end
    end
  end

  assign I2C.m_scl_o = 1'b0;
  assign I2C.m_scl_oe = scl_oe_r;
  assign I2C.m_sda_o = 1'b0;
  assign I2C.m_sda_oe = sda_oe_r;
  assign RX_DATA = rx_r;
  assign RX_VALID = rxv_r;
  assign ACK_OK = ack_r;
  assign IDLE = idle_r;

endmodule // irs_master

// >>> test/irs_sva.sv
`include "irs_defs.svh"

// ==========================================================
// Wire-level checks on the joined two-wire bus
// ==========================================================
module irs_sva #(
  parameter logic [6:0] SLAVE_ADDR = `IRS_SLAVE_ADDR
)(
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic m_scl_o,
  input wire logic m_scl_oe,
  input wire logic m_sda_o,
  input wire logic m_sda_oe,
  input wire logic s_sda_o,
  input wire logic s_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic scl_q, sda_q, mism_r, nack_r, rd_r;
  logic [3:0] cnt_r;
  logic [1:0] byt_r;
  logic [7:0] sh_r;
  wire rise_w = scl & ~scl_q;
  wire start_w = scl & scl_q & sda_q & ~sda;
  wire stop_w = scl & scl_q & ~sda_q & sda;
  wire ack_w = rise_w & (cnt_r == 4'h8);
  wire hit_w = (sh_r[7:1] == SLAVE_ADDR);

  always_ff @(posedge CLOCK)
  begin
    scl_q <= scl;
    sda_q <= sda;
  end

  // Byte tracker; the stray rise ahead of a repeated start is wiped by the start
  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N || start_w)
    begin
      cnt_r <= 4'h0;
      byt_r <= 2'h0;
      mism_r <= 1'b0;
      nack_r <= 1'b0;
    end
    else if (ack_w)
    begin
      cnt_r <= 4'h0;
      if (byt_r != 2'h3)
        byt_r <= byt_r + 2'h1;
      if (byt_r == 2'h0)
      begin
        rd_r <= sh_r[0];
        mism_r <= ~hit_w;
      end
      else if (rd_r & sda)
        nack_r <= 1'b1;
    end
    else if (rise_w)
    begin
      cnt_r <= cnt_r + 4'h1;
      sh_r <= {sh_r[6:0], sda};
    end
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);

  open_drain_a: assert property (!m_scl_o && !s_sda_o && !m_sda_o)
    else $error("output value driven high");
  slave_stable_a: assert property (scl && $past(scl) |-> $stable(s_sda_oe))
    else $error("slave moved data while clock high");
  master_owns_a: assert property (scl && $past(scl) && $changed(sda) |-> $changed(m_sda_oe))
    else $error("start or stop not made by master");
  clock_high_a: assert property ($rose(scl) |-> scl[*8])
    else $error("clock high phase too short");
  clock_low_a: assert property ($fell(scl) |-> !scl[*8])
    else $error("clock low phase too short");
  no_clash_a: assert property (scl |-> !(s_sda_oe && m_sda_oe))
    else $error("both ends drive data");
  addr_quiet_a: assert property (byt_r == 2'h0 && cnt_r != 4'h8 |-> !s_sda_oe)
    else $error("slave drove during address bits");
  ack_drive_a: assert property (ack_w && !mism_r && !nack_r && (byt_r == 2'h0 ? hit_w : !rd_r)
    |-> !sda)
    else $error("missing slave acknowledge");
  mism_quiet_a: assert property (mism_r |-> !s_sda_oe)
    else $error("slave drove after address mismatch");
  nack_quiet_a: assert property (nack_r |-> !s_sda_oe)
    else $error("slave drove after master nack");
  stop_quiet_a: assert property (stop_w |=> !s_sda_oe[*3])
    else $error("slave drove after stop");
endmodule // irs_sva

// >>> test/tb_top.sv
`include "irs_defs.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import irs_pkg::*;
  localparam irs_byte_t WADR = {`IRS_SLAVE_ADDR, 1'b0};
  localparam irs_byte_t RADR = {`IRS_SLAVE_ADDR, 1'b1};
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic cmd_valid = 1'b0;
  irs_cmd_e cmd_op = IRS_CMD_STOP;
  irs_byte_t cmd_data = 8'h00;
  logic cmd_ready, rx_valid, ack_ok, idle, reg_wr, reg_rd, busy, refused;
  irs_byte_t rx_data, reg_wdata, reg_rdata;
  irs_addr_t reg_addr;
  irs_byte_t mem [256];
  irs_byte_t d [5];
  logic [10:0] cq [$];
  logic [23:0] wr_q [$];
  irs_byte_t rd_q [$];
  irs_addr_t ra_q [$];
  int fail_count = 0;
  int cmp_count = 0;

  irs_if bus();
  assign reg_rdata = mem[reg_addr[7:0]];

  // Fast link rate keeps a byte near 360 cycles
  irs_master #(.SCL_KHZ(2500)) i_irs_master (.CLOCK(clock), .RESET_N(reset_n),
    .I2C(bus.master), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_OP(cmd_op),
    .CMD_DATA(cmd_data), .RX_DATA(rx_data), .RX_VALID(rx_valid), .ACK_OK(ack_ok),
    .IDLE(idle));
  irs_slave i_irs_slave (.CLOCK(clock), .RESET_N(reset_n), .I2C(bus.slave),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata), .BUSY(busy));
  irs_sva #(.SLAVE_ADDR(`IRS_SLAVE_ADDR)) i_irs_sva (.CLOCK(clock), .RESET_N(reset_n),
    .m_scl_o(bus.m_scl_o), .m_scl_oe(bus.m_scl_oe), .m_sda_o(bus.m_sda_o),
    .m_sda_oe(bus.m_sda_oe), .s_sda_o(bus.s_sda_o), .s_sda_oe(bus.s_sda_oe),
    .scl(bus.scl), .sda(bus.sda));

  initial
  begin
    forever #5 clock = ~clock;
  end

  task automatic check(string name, logic [23:0] seen, logic [23:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task finish_test();
    if (fail_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task add(irs_cmd_e op, irs_byte_t v);
    cq.push_back({op, v});
  endtask

  // Valid stays up between pushes so no edge sees two drives
  task push(logic [10:0] c);
    int n;
    n = 0;
    cmd_op <= irs_cmd_e'(c[10:8]);
    cmd_data <= c[7:0];
    cmd_valid <= 1'b1;
    @(posedge clock);
    while (cmd_ready !== 1'b1 && n < 3000)
    begin
      refused = 1'b1;
      n++;
      @(posedge clock);
    end
    if (n == 3000)
      fail_count++;
  endtask

  task run(logic exp_ack);
    int n;
    n = 0;
    refused = 1'b0;
    foreach (cq[i]) push(cq[i]);
    cmd_valid <= 1'b0;
    cq.delete();
    repeat (3) @(posedge clock);
    while (idle !== 1'b1 && n < 20000)
    begin
      n++;
      @(posedge clock);
    end
    if (n == 20000)
      fail_count++;
    repeat (10) @(posedge clock);
    check("ack_ok", ack_ok, exp_ack);
    check("busy", busy, 1'b0);
  endtask

  // ==========================================================
  // Result watcher and register file
  // ==========================================================
  always @(posedge clock)
  begin
    if (reg_wr === 1'b1)
    begin
      mem[reg_addr[7:0]] <= reg_wdata;
      if (wr_q.size() == 0)
        check("reg_wr", 1'b1, 1'b0);
      else
        check("reg_write", {reg_addr, reg_wdata}, wr_q.pop_front());
    end
    if (rx_valid === 1'b1)
    begin
      if (rd_q.size() == 0)
        check("rx_valid", 1'b1, 1'b0);
      else
        check("rx_data", rx_data, rd_q.pop_front());
    end
    if (reg_rd === 1'b1)
    begin
      if (ra_q.size() == 0)
        check("reg_rd", 1'b1, 1'b0);
      else
        check("reg_read", reg_addr, ra_q.pop_front());
    end
  end

  initial
  begin
    repeat (60000) @(posedge clock);
    fail_count++;
    finish_test();
  end

  // ==========================================================
  // Scenarios
  // ==========================================================
  initial
  begin
    void'($urandom(58));
    foreach (d[i]) d[i] = irs_byte_t'($urandom);
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    repeat (4) @(posedge clock);
    // Ten back-to-back commands overrun the eight-entry buffer
    add(IRS_CMD_START, 8'h00);
    add(IRS_CMD_WRITE, WADR);
    add(IRS_CMD_WRITE, 8'h5A);
    add(IRS_CMD_WRITE, 8'h10);
    foreach (d[i])
    begin
      add(IRS_CMD_WRITE, d[i]);
      wr_q.push_back({16'h5A10 + 16'(i), d[i]});
    end
    add(IRS_CMD_STOP, 8'h00);
    run(1'b1);
    check("refused", refused, 1'b1);
    // Foreign address must stay silent
    add(IRS_CMD_START, 8'h00);
    add(IRS_CMD_WRITE, WADR ^ 8'h02);
    add(IRS_CMD_WRITE, 8'h5A);
    add(IRS_CMD_STOP, 8'h00);
    run(1'b0);
    // Address-only write, then a separate read from that pointer
    add(IRS_CMD_START, 8'h00);
    add(IRS_CMD_WRITE, WADR);
    add(IRS_CMD_WRITE, 8'h5A);
    add(IRS_CMD_WRITE, 8'h12);
    add(IRS_CMD_STOP, 8'h00);
    run(1'b1);
    add(IRS_CMD_START, 8'h00);
    add(IRS_CMD_WRITE, RADR);
    add(IRS_CMD_READ, 8'h00);
    add(IRS_CMD_READ, 8'h00);
    add(IRS_CMD_READ_LAST, 8'h00);
    add(IRS_CMD_STOP, 8'h00);
    rd_q = {d[2], d[3], d[4]};
    ra_q = {16'h5A12, 16'h5A13, 16'h5A14};
    run(1'b0);
    // Combined read through a repeated start
    add(IRS_CMD_START, 8'h00);
    add(IRS_CMD_WRITE, WADR);
    add(IRS_CMD_WRITE, 8'h5A);
    add(IRS_CMD_WRITE, 8'h10);
    add(IRS_CMD_START, 8'h00);
    add(IRS_CMD_WRITE, RADR);
    add(IRS_CMD_READ, 8'h00);
    add(IRS_CMD_READ_LAST, 8'h00);
    add(IRS_CMD_STOP, 8'h00);
    rd_q = {d[0], d[1]};
    ra_q = {16'h5A10, 16'h5A11};
    run(1'b0);
    check("left_wr", 24'(wr_q.size()), 24'h000000);
    check("left_rd", 24'(rd_q.size()), 24'h000000);
    check("left_ra", 24'(ra_q.size()), 24'h000000);
    finish_test();
  end
endmodule // tb_top
